// ### sep_spi_eeprom.sv
// Notes on behaviour
// - After reset the write latch is clear, so no write is accepted.
// - Writes need the latch set; array writes must miss the guarded region.
// - Latch-set opcode counts only if select rises right after its eight bits.
// - Latch-clear opcode resets the write latch.
// - Byte write: opcode, 24-bit address, data; only low 17 address bits count.
// - Programming starts at the select rise ending a valid write sequence.
// - During a write cycle every command but status read is ignored.
// - Busy flag reads one during the write cycle, zero afterwards.
// - Up to 256 bytes per page; in-page address wraps, overwriting earlier bytes.
// - Finishing a byte, page or status write clears the write latch.
// - Id page writes need the id select bit; low 8 address bits pick the byte.
// - Id page write needs bits 16:15 unguarded; full guard blocks it.
// - Id lock set makes every id page write ignored.
// - Status write changes only bits 2, 3, 4, 6 and 7.
// - Protect pin low with pin enable set blocks status writes.
// - Protect pin falling while selected aborts a pending status write only.
// - Read: opcode, address, then data streams with address wrapping to zero.
// - Status read shifts the status byte out, also during busy.
// - While paused the output floats from the first falling clock edge on and the input is ignored.
// - Unknown opcode: no action, output floats until deselect.
// - Opcodes: 06 set latch, 04 clear, 05 status read, 01 status write, 03, 02.
// - Status bits 7..0: pin enable, id select, 0, id lock, guards, latch, busy.
// - Guard pair: none, top quarter, top half, whole array.
// - Input sampled on rising serial clock, output shifted on falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "sep_defines.svh"

module sep_spi_eeprom #(
  parameter int WC_CYCLES = `SEP_TWC_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic hold_n_in,
  input wire logic wp_n_in,
  input wire logic [7:0] rd_data_in,
  output logic so_out,
  output logic so_oe_out,
  output logic [16:0] rd_addr_out,
  output logic rd_id_out,
  output sep_pkg::sep_mem_wr_t mem_wr_out,
  output logic [7:0] status_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers and crossings.

  function automatic logic guard_hit(input logic [1:0] guard, input logic [16:0] addr);
    case (guard)
      2'b01: guard_hit = (addr >= `SEP_QUARTER_BASE);
      2'b10: guard_hit = (addr >= `SEP_HALF_BASE);
      2'b11: guard_hit = 1'b1;
      default: guard_hit = 1'b0;
    endcase
  endfunction : guard_hit

  sep_pkg::sep_link_state_t ls_q;
  sep_pkg::sep_link_state_t ls_d;
  logic [2:0] bcnt_q;
  logic [2:0] bcnt_d;
  logic [1:0] acnt_q;
  logic [1:0] acnt_d;
  logic [7:0] shreg_q;
  logic [7:0] shreg_d;
  logic [23:0] addr_q;
  logic [23:0] addr_d;
  logic [7:0] wptr_q;
  logic [7:0] wptr_d;
  logic is_wr_q;
  logic is_wr_d;
  logic [16:0] rd_addr_d;
  logic rd_id_d;
  sep_pkg::sep_act_t act_q;
  sep_pkg::sep_act_t act_d;
  logic seq_q;
  logic seq_d;
  logic buf_clr;
  logic buf_we;
  logic [7:0] byte_in;
  logic [23:0] addr_full;
  logic so_d;
  logic oe_d;
  logic [7:0] out_byte;
  logic [7:0] stat_l;
  logic busy_l;

  logic [7:0] stat_q;
  logic [7:0] stat_d;
  sep_pkg::sep_cyc_state_t cyc_q;
  sep_pkg::sep_cyc_state_t cyc_d;
  logic [7:0] idx_q;
  logic [7:0] idx_d;
  logic [17:0] tmr_q;
  logic [17:0] tmr_d;
  sep_pkg::sep_act_t cur_q;
  sep_pkg::sep_act_t cur_d;
  sep_pkg::sep_mem_wr_t mwr_d;
  logic seen_q;
  logic seen_d;
  logic abort_q;
  logic abort_d;
  logic cs_prev_q;
  logic wp_prev_q;
  logic [1:0] pins_s;
  logic cs_n_s;
  logic wp_n_s;
  logic seq_s;
  logic [7:0] buf_data;
  logic buf_vld;
  logic [7:0] write_state_cmd_v;
  logic wr_ok;
  logic pin_lock;
  logic cs_rise;
  logic cs_fall;
  logic wp_fall;
  logic fresh;

  sep_sync #(.WIDTH(2)) u_pin_sync (
    .clk_in(sys_clk_in),
    .d_in({cs_n_in, wp_n_in}),
    .q_out(pins_s)
  );

  sep_sync #(.WIDTH(1)) u_seq_sync (
    .clk_in(sys_clk_in),
    .d_in(seq_q),
    .q_out(seq_s)
  );

  // Status bits barely move while selected; the opcode takes eight edges, so the
  // copy has settled before anything reads it.
  sep_sync #(.WIDTH(8)) u_stat_sync (
    .clk_in(sck_in),
    .d_in(stat_q),
    .q_out(stat_l)
  );

  sep_page_buf u_page_buf (
    .clk_in(sck_in),
    .clear_in(buf_clr),
    .wr_en_in(buf_we),
    .wr_idx_in(wptr_q),
    .wr_data_in(byte_in),
    .rd_idx_in(idx_q),
    .rd_data_out(buf_data),
    .rd_valid_out(buf_vld)
  );

  assign cs_n_s = pins_s[1];
  assign wp_n_s = pins_s[0];
  assign busy_l = stat_l[`SEP_ST_BUSY];

  ////////////////////////////////////////////////////////////////////////////////
  // Link side, serial clock domain; deselect clears the per-selection state.

  always_comb begin
    ls_d = ls_q;
    bcnt_d = bcnt_q;
    acnt_d = acnt_q;
    shreg_d = shreg_q;
    addr_d = addr_q;
    wptr_d = wptr_q;
    is_wr_d = is_wr_q;
    rd_addr_d = rd_addr_out;
    rd_id_d = rd_id_out;
    act_d = act_q;
    seq_d = seq_q;
    buf_clr = 1'b0;
    buf_we = 1'b0;
    byte_in = {shreg_q[6:0], si_in};
    addr_full = {addr_q[22:0], si_in};
    if (hold_n_in) begin
      bcnt_d = bcnt_q + 3'h1;
      shreg_d = byte_in;
      if (ls_q != sep_pkg::LS_RDATA) begin
        act_d.kind = sep_pkg::ACT_NONE;
      end
      case (ls_q)
        sep_pkg::LS_OPC: begin
          if (bcnt_q == 3'h7) begin
            // Marking against the committed copy keeps the marker known from the first
            // opcode on; that copy only moves while the link clock stands still.
            seq_d = ~seen_q;
            if (busy_l && byte_in != `SEP_OP_RD_STATE) begin
              ls_d = sep_pkg::LS_IGN;
            end else begin
              case (byte_in)
                `SEP_OP_SET_LATCH: begin
                  act_d.kind = sep_pkg::ACT_SET;
                  ls_d = sep_pkg::LS_IGN;
                end
                `SEP_OP_CLR_LATCH: begin
                  act_d.kind = sep_pkg::ACT_CLR;
                  ls_d = sep_pkg::LS_IGN;
                end
                `SEP_OP_RD_STATE: begin
                  ls_d = sep_pkg::LS_SOUT;
                end
                `SEP_OP_WR_STATE: begin
                  ls_d = sep_pkg::LS_SDATA;
                end
                `SEP_OP_READ: begin
                  ls_d = sep_pkg::LS_ADDR;
                  is_wr_d = 1'b0;
                end
                `SEP_OP_WRITE: begin
                  ls_d = sep_pkg::LS_ADDR;
                  is_wr_d = 1'b1;
                  buf_clr = 1'b1;
                end
                default: begin
                  ls_d = sep_pkg::LS_IGN;
                end
              endcase
            end
          end
        end
        sep_pkg::LS_ADDR: begin
          addr_d = addr_full;
          if (bcnt_q == 3'h7) begin
            acnt_d = acnt_q + 2'h1;
            if (acnt_q == 2'h2) begin
              if (is_wr_q) begin
                ls_d = sep_pkg::LS_WDATA;
                wptr_d = addr_full[7:0];
                act_d.addr = addr_full[16:0];
                act_d.id_sel = stat_l[`SEP_ST_ID_SEL];
              end else begin
                ls_d = sep_pkg::LS_RDATA;
                act_d.kind = sep_pkg::ACT_READ;
                rd_id_d = stat_l[`SEP_ST_ID_SEL];
                if (stat_l[`SEP_ST_ID_SEL]) begin
                  rd_addr_d = {9'h000, addr_full[7:0]};
                end else begin
                  rd_addr_d = addr_full[16:0];
                end
              end
            end
          end
        end
        sep_pkg::LS_WDATA: begin
          if (bcnt_q == 3'h7) begin
            buf_we = 1'b1;
            wptr_d = wptr_q + 8'h01;
            act_d.kind = sep_pkg::ACT_WRITE;
          end
        end
        sep_pkg::LS_SDATA: begin
          if (bcnt_q == 3'h7) begin
            act_d.kind = sep_pkg::ACT_WRITE_STATE_CMD;
            act_d.data = byte_in;
            ls_d = sep_pkg::LS_IGN;
          end
        end
        sep_pkg::LS_RDATA: begin
          if (bcnt_q == 3'h7) begin
            if (rd_id_out) begin
              rd_addr_d = {9'h000, rd_addr_out[7:0] + 8'h01};
            end else begin
              rd_addr_d = rd_addr_out + 17'h00001;
            end
          end
        end
        sep_pkg::LS_SOUT: begin
          ls_d = sep_pkg::LS_SOUT;
        end
        sep_pkg::LS_IGN: begin
          ls_d = sep_pkg::LS_IGN;
        end
        default: begin
          ls_d = sep_pkg::LS_IGN;
        end
      endcase
    end
  end

  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      ls_q <= sep_pkg::LS_OPC;
      bcnt_q <= 3'h0;
      acnt_q <= 2'h0;
      shreg_q <= 8'h00;
      addr_q <= 24'h000000;
      wptr_q <= 8'h00;
      is_wr_q <= 1'b0;
      rd_addr_out <= 17'h00000;
      rd_id_out <= 1'b0;
    end else begin
      ls_q <= ls_d;
      bcnt_q <= bcnt_d;
      acnt_q <= acnt_d;
      shreg_q <= shreg_d;
      addr_q <= addr_d;
      wptr_q <= wptr_d;
      is_wr_q <= is_wr_d;
      rd_addr_out <= rd_addr_d;
      rd_id_out <= rd_id_d;
    end
  end

  // The request and its marker must outlive the selection, so deselect leaves them alone.
  always_ff @(posedge sck_in) begin
    act_q <= act_d;
    seq_q <= seq_d;
  end

  always_comb begin
    out_byte = (ls_q == sep_pkg::LS_SOUT) ? stat_l : rd_data_in;
    so_d = out_byte[3'h7 - bcnt_q];
    oe_d = hold_n_in && (ls_q == sep_pkg::LS_SOUT || ls_q == sep_pkg::LS_RDATA);
  end

  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      so_out <= 1'b0;
      so_oe_out <= 1'b0;
    end else begin
      so_out <= so_d;
      so_oe_out <= oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command commit and write cycle, system clock domain.

  always_comb begin
    stat_d = stat_q;
    cyc_d = cyc_q;
    idx_d = idx_q;
    tmr_d = tmr_q;
    cur_d = cur_q;
    seen_d = seen_q;
    abort_d = abort_q;
    mwr_d = '0;
    cs_rise = cs_n_s && !cs_prev_q;
    cs_fall = !cs_n_s && cs_prev_q;
    wp_fall = !wp_n_s && wp_prev_q;
    fresh = (seq_s != seen_q);
    pin_lock = stat_q[`SEP_ST_PIN_EN] && !wp_n_s;
    write_state_cmd_v = (act_q.data & `SEP_ST_WR_MASK) | (stat_q & ~`SEP_ST_WR_MASK);
    write_state_cmd_v[`SEP_ST_ID_LOCK] = stat_q[`SEP_ST_ID_LOCK] | act_q.data[`SEP_ST_ID_LOCK];
    if (act_q.data[`SEP_ST_ID_SEL] && act_q.data[`SEP_ST_ID_LOCK]) begin
      write_state_cmd_v[`SEP_ST_ID_SEL] = stat_q[`SEP_ST_ID_SEL];
      write_state_cmd_v[`SEP_ST_ID_LOCK] = stat_q[`SEP_ST_ID_LOCK];
    end
    if (act_q.id_sel) begin
      wr_ok = !stat_q[`SEP_ST_ID_LOCK] &&
        !guard_hit(stat_q[3:2], {act_q.addr[16:15], 15'h0000});
    end else begin
      wr_ok = !guard_hit(stat_q[3:2], act_q.addr);
    end
    if (cs_fall) begin
      abort_d = 1'b0;
    end
    if (wp_fall && !cs_n_s) begin
      abort_d = 1'b1;
    end
    if (cs_rise && fresh) begin
      seen_d = seq_s;
    end
    case (cyc_q)
      sep_pkg::CYC_IDLE: begin
        if (cs_rise && fresh) begin
          case (act_q.kind)
            sep_pkg::ACT_SET: begin
              stat_d[`SEP_ST_LATCH] = 1'b1;
            end
            sep_pkg::ACT_CLR: begin
              stat_d[`SEP_ST_LATCH] = 1'b0;
            end
            sep_pkg::ACT_WRITE_STATE_CMD: begin
              if (stat_q[`SEP_ST_LATCH] && !pin_lock && !abort_q) begin
                cur_d = act_q;
                cur_d.data = write_state_cmd_v;
                stat_d[`SEP_ST_BUSY] = 1'b1;
                tmr_d = 18'h00000;
                cyc_d = sep_pkg::CYC_WAIT;
              end
            end
            sep_pkg::ACT_WRITE: begin
              if (stat_q[`SEP_ST_LATCH] && wr_ok) begin
                cur_d = act_q;
                stat_d[`SEP_ST_BUSY] = 1'b1;
                idx_d = 8'h00;
                cyc_d = sep_pkg::CYC_PROG;
              end
            end
            sep_pkg::ACT_READ: begin
              stat_d[`SEP_ST_ID_SEL] = 1'b0;
            end
            default: begin
              stat_d = stat_q;
            end
          endcase
        end
      end
      sep_pkg::CYC_PROG: begin
        // Every loaded slot goes out once; empty slots leave the array untouched.
        if (buf_vld) begin
          mwr_d.en = 1'b1;
          mwr_d.id_sel = cur_q.id_sel;
          mwr_d.data = buf_data;
          if (cur_q.id_sel) begin
            mwr_d.addr = {9'h000, idx_q};
          end else begin
            mwr_d.addr = {cur_q.addr[16:8], idx_q};
          end
        end
        idx_d = idx_q + 8'h01;
        if (idx_q == 8'hff) begin
          tmr_d = 18'h00000;
          cyc_d = sep_pkg::CYC_WAIT;
        end
      end
      sep_pkg::CYC_WAIT: begin
        tmr_d = tmr_q + 18'h00001;
        if (tmr_q == 18'(WC_CYCLES - 1)) begin
          if (cur_q.kind == sep_pkg::ACT_WRITE_STATE_CMD) begin
            stat_d = cur_q.data;
          end else begin
            stat_d[`SEP_ST_ID_SEL] = 1'b0;
          end
          stat_d[`SEP_ST_BUSY] = 1'b0;
          stat_d[`SEP_ST_LATCH] = 1'b0;
          cyc_d = sep_pkg::CYC_IDLE;
        end
      end
      default: begin
        cyc_d = sep_pkg::CYC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      stat_q <= `SEP_ST_RESET;
      cyc_q <= sep_pkg::CYC_IDLE;
      idx_q <= 8'h00;
      tmr_q <= 18'h00000;
      cur_q <= '0;
      mem_wr_out <= '0;
      seen_q <= 1'b0;
      abort_q <= 1'b0;
      cs_prev_q <= 1'b1;
      wp_prev_q <= 1'b1;
      status_out <= `SEP_ST_RESET;
    end else begin
      stat_q <= stat_d;
      cyc_q <= cyc_d;
      idx_q <= idx_d;
      tmr_q <= tmr_d;
      cur_q <= cur_d;
      mem_wr_out <= mwr_d;
      seen_q <= seen_d;
      abort_q <= abort_d;
      cs_prev_q <= cs_n_s;
      wp_prev_q <= wp_n_s;
      status_out <= stat_d;
    end
  end

endmodule : sep_spi_eeprom

`default_nettype wire

// ### sep_defines.svh
`ifndef SEP_DEFINES_SVH
`define SEP_DEFINES_SVH

// Opcodes.
`define SEP_OP_SET_LATCH 8'h06
`define SEP_OP_CLR_LATCH 8'h04
`define SEP_OP_RD_STATE 8'h05
`define SEP_OP_WR_STATE 8'h01
`define SEP_OP_READ 8'h03
`define SEP_OP_WRITE 8'h02

// Status byte bit positions.
`define SEP_ST_BUSY 0
`define SEP_ST_LATCH 1
`define SEP_ST_GUARD_LO 2
`define SEP_ST_GUARD_HI 3
`define SEP_ST_ID_LOCK 4
`define SEP_ST_ID_SEL 6
`define SEP_ST_PIN_EN 7
`define SEP_ST_WR_MASK 8'hdc
`define SEP_ST_RESET 8'h00

// Protected range bases.
`define SEP_QUARTER_BASE 17'h18000
`define SEP_HALF_BASE 17'h10000

// Write cycle time.
`define SEP_TWC_MS 5
`define SEP_SYS_CLK_KHZ 40000
`define SEP_TWC_CYCLES (`SEP_TWC_MS * `SEP_SYS_CLK_KHZ)

`endif

// ### sep_pkg.sv
`default_nettype none

package sep_pkg;

  typedef enum logic [6:0] {
    LS_OPC = 7'b0000001,
    LS_ADDR = 7'b0000010,
    LS_WDATA = 7'b0000100,
    LS_SDATA = 7'b0001000,
    LS_RDATA = 7'b0010000,
    LS_SOUT = 7'b0100000,
    LS_IGN = 7'b1000000
  } sep_link_state_t;

  typedef enum logic [2:0] {
    ACT_NONE = 3'h0,
    ACT_SET = 3'h1,
    ACT_CLR = 3'h2,
    ACT_WRITE_STATE_CMD = 3'h3,
    ACT_WRITE = 3'h4,
    ACT_READ = 3'h5
  } sep_act_kind_t;

  typedef struct packed {
    sep_act_kind_t kind;
    logic id_sel;
    logic [16:0] addr;
    logic [7:0] data;
  } sep_act_t;

  typedef enum logic [2:0] {
    CYC_IDLE = 3'b001,
    CYC_PROG = 3'b010,
    CYC_WAIT = 3'b100
  } sep_cyc_state_t;

  typedef struct packed {
    logic en;
    logic id_sel;
    logic [16:0] addr;
    logic [7:0] data;
  } sep_mem_wr_t;

endpackage : sep_pkg

`default_nettype wire

// ### sep_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sep_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in) begin
    meta_q <= d_in;
    q_out <= meta_q;
  end

endmodule : sep_sync

`default_nettype wire

// ### sep_page_buf.sv
`timescale 1ns/1ps
`default_nettype none

module sep_page_buf (
  input wire logic clk_in,
  input wire logic clear_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_idx_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] rd_idx_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out
);

  logic [7:0] mem_q [256];
  logic [255:0] vld_q;
  logic [255:0] vld_d;

  always_comb begin
    vld_d = vld_q;
    if (clear_in) begin
      vld_d = '0;
    end
    if (wr_en_in) begin
      vld_d[wr_idx_in] = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    vld_q <= vld_d;
    if (wr_en_in) begin
      mem_q[wr_idx_in] <= wr_data_in;
    end
  end

  // The reader works only while the writer is held off, so the contents are static then.
  assign rd_data_out = mem_q[rd_idx_in];
  assign rd_valid_out = vld_q[rd_idx_in];

endmodule : sep_page_buf

`default_nettype wire

// ### sep_spi_eeprom_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module sep_spi_eeprom_checker #(
  parameter int WC_CYCLES = 50
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic hold_n_in,
  input wire logic so_oe_out,
  input wire sep_pkg::sep_mem_wr_t mem_wr_out,
  input wire logic [7:0] status_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  AST_FIXED_ZERO: assert property (status_out[5] == 1'b0)
    else $error("status bit 5 not zero");
  AST_WR_LATCH: assert property (mem_wr_out.en |-> status_out[1])
    else $error("byte written without latch");
  AST_WR_BUSY: assert property (mem_wr_out.en |=> status_out[0])
    else $error("byte written while not busy");
  AST_START_DESEL: assert property ($rose(status_out[0]) |-> cs_n_in)
    else $error("write cycle began while selected");
  AST_GUARD: assert property (mem_wr_out.en && !mem_wr_out.id_sel |-> !(status_out[3] ?
    (status_out[2] || mem_wr_out.addr[16]) : (status_out[2] && mem_wr_out.addr[16:15] == 2'b11)))
    else $error("guarded byte written");
  AST_ID_GUARD: assert property (mem_wr_out.en && mem_wr_out.id_sel |->
    !status_out[4] && status_out[3:2] != 2'b11)
    else $error("id page written while protected");
  AST_LATCH_END: assert property ($fell(status_out[0]) |-> !status_out[1])
    else $error("latch still set after write cycle");
  // Pause drops the enable one falling edge late because the output is registered.
  AST_HOLD: assert property (@(negedge sck_in) disable iff (cs_n_in)
    !hold_n_in && !$past(hold_n_in) |-> !so_oe_out)
    else $error("output driven during pause");
  AST_RESET: assert property (disable iff (1'b0) !rst_n_in |=>
    status_out == 8'h00 && !mem_wr_out.en)
    else $error("state not cleared by reset");
endmodule : sep_spi_eeprom_checker

bind sep_spi_eeprom sep_spi_eeprom_checker #(.WC_CYCLES(WC_CYCLES)) chk_u (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sck_in(sck_in), .cs_n_in(cs_n_in),
  .hold_n_in(hold_n_in), .so_oe_out(so_oe_out), .mem_wr_out(mem_wr_out),
  .status_out(status_out));

`default_nettype wire

// ### sep_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sep_host_model (
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  output logic hold_n_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  logic [7:0] tx [0:259];
  logic [7:0] rx [0:259];
  int hold_at = -1;
  logic hold_oe = 1'b0;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    hold_n_out = 1'b1;
  end
  // Mode 0: the clock rests low and moves only inside a frame.
  task automatic frame(input int nbits);
    int i;
    int k;
    #7 cs_n_out = 1'b0;
    #15;
    for (i = 0; i < nbits; i++) begin
      if (i == hold_at) begin
        hold_n_out = 1'b0;
        for (k = 0; k < 3; k++) begin
          si_out = ~si_out;
          #15 hold_oe = hold_oe | (k > 0 && so_oe_in);
          sck_out = 1'b1;
          #15 sck_out = 1'b0;
        end
        #15 hold_n_out = 1'b1;
      end
      si_out = tx[i / 8][7 - i % 8];
      #15 sck_out = 1'b1;
      rx[i / 8][7 - i % 8] = so_in;
      #15 sck_out = 1'b0;
    end
    #15 cs_n_out = 1'b1;
    si_out = ~si_out;
    #300;
  endtask : frame
endmodule : sep_host_model

`default_nettype wire

// ### tb_sep_spi_eeprom.sv
`timescale 1ns/1ps
`default_nettype none

module tb_sep_spi_eeprom;
  logic sys_clk_in, rst_n_in, wp_n_in, pat_q, sck, cs_n, si, hold_n, so_w;
  logic so_out, so_oe_out, rd_id_out;
  logic [16:0] rd_addr_out;
  logic [7:0] rd_data_in, status_out;
  sep_pkg::sep_mem_wr_t mem_wr_out;
  logic [7:0] mem [0:131071];
  logic [7:0] idp [0:255];
  int error_cnt = 0, samples_checked = 0, wr_cnt = 0, oe_cnt = 0;
  // A released output line shows a moving pattern, never a held value.
  assign so_w = so_oe_out ? so_out : pat_q;
  assign rd_data_in = rd_id_out ? idp[rd_addr_out[7:0]] : mem[rd_addr_out];
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    pat_q <= ~pat_q;
    if (so_oe_out === 1'b1) oe_cnt <= oe_cnt + 1;
    if (mem_wr_out.en === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      if (mem_wr_out.id_sel) idp[mem_wr_out.addr[7:0]] <= mem_wr_out.data;
      else mem[mem_wr_out.addr] <= mem_wr_out.data;
    end
  end
  sep_spi_eeprom #(.WC_CYCLES(50)) dut_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .hold_n_in(hold_n), .wp_n_in(wp_n_in), .rd_data_in(rd_data_in), .so_out(so_out),
    .so_oe_out(so_oe_out), .rd_addr_out(rd_addr_out), .rd_id_out(rd_id_out),
    .mem_wr_out(mem_wr_out), .status_out(status_out));
  sep_host_model hm (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n),
    .so_in(so_w), .so_oe_in(so_oe_out));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic idle();
    int i;
    repeat (10) @(posedge sys_clk_in);
    for (i = 0; i < 3000 && status_out[0] !== 1'b0; i++) @(posedge sys_clk_in);
    if (i == 3000) begin
      error_cnt++;
      summarize();
    end
  endtask : idle
  task automatic cmd(input logic [7:0] op, input int nbits);
    hm.tx[0] = op;
    hm.frame(nbits);
  endtask : cmd
  task automatic xfer(input logic [7:0] op, input logic [23:0] a, input int nbits);
    {hm.tx[1], hm.tx[2], hm.tx[3]} = a;
    cmd(op, nbits);
  endtask : xfer
  task automatic write_state_cmd(input logic [7:0] d);
    cmd(8'h06, 8);
    hm.tx[1] = d;
    cmd(8'h01, 16);
    idle();
  endtask : write_state_cmd
  task automatic wr(input logic [23:0] a, input int n);
    cmd(8'h06, 8);
    xfer(8'h02, a, 32 + 8 * n);
    idle();
  endtask : wr
  function automatic bit guarded(input logic [1:0] g, input logic [16:0] a);
    return g == 2'b11 || (g == 2'b10 && a >= 17'h10000) || (g == 2'b01 && a >= 17'h18000);
  endfunction : guarded
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int i, g, base;
    logic [7:0] d;
    logic [16:0] a;
    logic [16:0] at [0:2];
    rst_n_in = 1'b0;
    wp_n_in = 1'b1;
    pat_q = 1'b0;
    void'($urandom(32'h592d));
    for (i = 0; i < 131072; i++) mem[i] = $urandom;
    repeat (5) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    chk(status_out, 8'h00);
    hm.tx[4] = 8'h5a;
    xfer(8'h02, 24'h000100, 40);
    chk(wr_cnt, 0);
    cmd(8'h06, 8);
    chk(status_out[1], 1'b1);
    cmd(8'h04, 8);
    chk(status_out[1], 1'b0);
    cmd(8'h06, 9);
    chk(status_out[1], 1'b0);
    a = 17'($urandom);
    d = $urandom;
    hm.tx[4] = d;
    cmd(8'h06, 8);
    xfer(8'h02, {7'h5b, a}, 40);
    cmd(8'h05, 16);
    chk(hm.rx[1][1:0], 2'b11);
    hm.tx[4] = ~d;
    xfer(8'h02, {7'h00, a ^ 17'h1}, 40);
    idle();
    chk(wr_cnt, 1);
    chk(mem[a], d);
    chk(status_out, 8'h00);
    cmd(8'h06, 8);
    xfer(8'h02, 24'h000200, 36);
    repeat (20) @(posedge sys_clk_in);
    chk(wr_cnt, 1);
    a = {9'($urandom), 8'h80};
    for (i = 0; i < 256; i++) hm.tx[4 + i] = $urandom;
    wr(a, 256);
    chk(wr_cnt, 257);
    for (i = 0; i < 256; i++) chk(mem[{a[16:8], 8'(i + 128)}], hm.tx[4 + i]);
    at = '{17'h1c000, 17'h14000, 17'h04000};
    for (g = 0; g < 4; g++) begin
      write_state_cmd({4'h0, 2'(g), 2'b11});
      chk(status_out, {4'h0, 2'(g), 2'b00});
      for (i = 0; i < 3; i++) begin
        base = wr_cnt;
        wr({7'h00, at[i]}, 1);
        chk(wr_cnt - base, guarded(2'(g), at[i]) ? 0 : 1);
      end
    end
    write_state_cmd(8'h80);
    @(posedge sys_clk_in) wp_n_in <= 1'b0;
    write_state_cmd(8'h84);
    chk(status_out, 8'h82);
    @(posedge sys_clk_in) wp_n_in <= 1'b1;
    hm.tx[1] = 8'h88;
    fork
      cmd(8'h01, 16);
      begin
        #250 @(posedge sys_clk_in) wp_n_in <= 1'b0;
        #100 @(posedge sys_clk_in) wp_n_in <= 1'b1;
      end
    join
    idle();
    chk(status_out, 8'h82);
    @(posedge sys_clk_in) wp_n_in <= 1'b1;
    write_state_cmd(8'h00);
    @(posedge sys_clk_in) wp_n_in <= 1'b0;
    write_state_cmd(8'h08);
    chk(status_out, 8'h08);
    hm.hold_at = 68;
    xfer(8'h03, 24'hc1fffe, 72);
    hm.hold_at = -1;
    chk(hm.hold_oe, 1'b0);
    for (i = 0; i < 4; i++) chk(hm.rx[4 + i], mem[17'(i + 17'h1fffe)]);
    base = oe_cnt;
    cmd(8'hff, 24);
    chk(oe_cnt - base, 0);
    a = {2'b01, 7'h3a, 8'h21};
    for (g = 0; g < 3; g++) begin
      write_state_cmd(g == 0 ? 8'h40 : (g == 1 ? 8'h4c : 8'h10));
      if (g == 2) write_state_cmd(8'h40);
      d = $urandom;
      hm.tx[4] = d;
      base = wr_cnt;
      wr({7'h2a, a}, 1);
      chk(wr_cnt - base, g == 0 ? 1 : 0);
      if (g == 0) begin
        write_state_cmd(8'h40);
        xfer(8'h03, {7'h2a, a}, 40);
        chk(hm.rx[4], d);
      end
    end
    summarize();
  end
endmodule : tb_sep_spi_eeprom

`default_nettype wire
